// file: hdl/msf_pkg.sv
package msf_pkg;
	// bus geometry, switch and axis counts
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int STRB_W = 4;
	localparam int NUM_PSW = 8;
	localparam int NUM_AXES = 4;
	localparam int AXIS_SEL_W = 2;
	// register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_INPOS_RANGE = 8'h04;
	localparam logic [7:0] OFS_WORK_COUNT = 8'h08;
	localparam logic [7:0] OFS_WORK_MAX = 8'h0C;
	localparam logic [7:0] OFS_ABS_TOL = 8'h10;
	localparam logic [7:0] OFS_STATUS = 8'h14;
	localparam logic [7:0] OFS_PSW_AXIS = 8'h18;
	localparam logic [7:0] OFS_PSW_BASE = 8'h20;
	localparam logic [7:0] OFS_PSW_END = 8'h60;
	// control fields
	localparam int CTRL_SERIAL_LINK = 0;
	localparam int CTRL_ABS_DETECT = 1;
	localparam logic [1:0] CTRL_RST = 2'h0;
	// status fields
	localparam int ST_INDEX_PASSED = 0;
	localparam int ST_IN_POSITION = 1;
	localparam int ST_TORQUE_LIMIT = 2;
	localparam int ST_RETRACT_POSSIBLE = 3;
	localparam int ST_COUNT_OVER = 4;
	localparam int ST_ABS_WARNING = 5;
	localparam int ST_ZERO_INIT = 8;
	localparam int ST_PSW = 16;
	localparam int ST_AXIS_VALID = 24;
	// reset values and count saturation value
	localparam logic [31:0] INPOS_RANGE_RST = 32'h0000_0000;
	localparam logic [31:0] WORK_COUNT_RST = 32'h0000_0000;
	localparam logic [31:0] WORK_MAX_RST = 32'h0000_0000;
	localparam logic [31:0] ABS_TOL_RST = 32'h0000_0000;
	localparam logic [15:0] PSW_AXIS_RST = 16'h0000;
	localparam logic [31:0] LIMIT_RST = 32'h0000_0000;
	localparam logic [31:0] COUNT_SAT = 32'hFFFF_FFFF;
	// axi responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// timing
	localparam int CLK_PERIOD_NS = 10;
	localparam real PSW_LAG_LIMIT_S = 0.06;
	localparam int PSW_LAG_CYCLES = int'($floor(PSW_LAG_LIMIT_S * 1.0e9 / CLK_PERIOD_NS));
	localparam int PSW_PIPE_CYCLES = 1;
endpackage

// file: hdl/msf_flags.sv
// The address map and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
// Notes on behaviour
// - index-passed flag sets when the spindle encoder index phase passes
// - index-passed flag clears when spindle servo-on or ready status drops
// - index-passed flag only produced with the high-speed serial link configured
// - in sync tap with servo on, in-position set while droop within range
// - in-position flag held on whenever synchronous tapping is not commanded
// - in sync tap with servo on, in-position cleared once droop exceeds range
// - torque-limit-active follows first or second torque-limit request
// - retract-possible sets on tap stop in cutting feed by estop, reset, or power loss with absolute detection enabled
// - retract-possible clears on completed tap retract or manual tap axis move
// - tap retract request acts only while retract-possible is set
// - work-count-over set when count reaches or exceeds the configured maximum
// - work-count-over never set while the configured maximum is zero
// - absolute warning when power-on versus power-off position moved beyond tolerance with absolute detection enabled
// - eight range switches on while selected axis position is inside range
// - range limits accepted in either order, smaller to larger forms range
// - limits compared against basic machine coordinate axis position
// - absolute mode: switches valid at power-up following completed zero init
// - incremental mode: switches off until first reference return after power-on
// - switch update lag stays below 0.06 s minus position loop constant
// - per-axis zero-init-completed set when machine coordinates are established with absolute detection enabled
// - zero-init-completed clears on restart of initialization or power cycle
module msf_flags #(
	parameter int PSW_LAG_MAX_CYCLES = msf_pkg::PSW_LAG_CYCLES
) (
	// clock and reset
	input wire logic CLK,
	input wire logic RESET,
	// axi4-lite write address
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	input wire logic [msf_pkg::ADDR_W-1:0] S_AXI_AWADDR,
	// axi4-lite write data
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	input wire logic [msf_pkg::DATA_W-1:0] S_AXI_WDATA,
	input wire logic [msf_pkg::STRB_W-1:0] S_AXI_WSTRB,
	// axi4-lite write response
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	output logic [1:0] S_AXI_BRESP,
	// axi4-lite read
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	input wire logic [msf_pkg::ADDR_W-1:0] S_AXI_ARADDR,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	output logic [msf_pkg::DATA_W-1:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	// spindle conditions
	input wire logic SPINDLE_INDEX_PULSE,
	input wire logic SPINDLE_SERVO_ON_STATUS,
	input wire logic SPINDLE_READY_STATUS,
	input wire logic SYNC_TAP_CMD,
	input wire logic signed [31:0] SPINDLE_DROOP,
	input wire logic TORQUE_LIMIT_REQ_FIRST,
	input wire logic TORQUE_LIMIT_REQ_SECOND,
	// tapping cycle conditions
	input wire logic TAP_CYCLE_ACTIVE,
	input wire logic IN_CUT_FEED_REGION,
	input wire logic EMERGENCY_STOP,
	input wire logic RESET_STOP,
	input wire logic POWER_LOSS,
	input wire logic TAP_RETRACT_REQUEST,
	input wire logic TAP_RETRACT_DONE,
	input wire logic TAP_AXIS_MANUAL_MOVE,
	// work count and power-up
	input wire logic WORK_COUNT_INC,
	input wire logic POWER_ON_PULSE,
	input wire logic signed [31:0] POS_AT_POWER_OFF,
	input wire logic signed [31:0] POS_AT_POWER_ON,
	// axes
	input wire logic [msf_pkg::NUM_AXES*32-1:0] AXIS_POS,
	input wire logic [msf_pkg::NUM_AXES-1:0] REF_RETURN_DONE,
	input wire logic [msf_pkg::NUM_AXES-1:0] ZERO_INIT_START,
	input wire logic [msf_pkg::NUM_AXES-1:0] ZERO_INIT_ESTABLISHED,
	// status flags
	output logic SPINDLE_INDEX_PASSED,
	output logic POS_LOOP_IN_POSITION,
	output logic SPINDLE_TORQUE_LIMIT_ACTIVE,
	output logic TAP_RETRACT_POSSIBLE,
	output logic TAP_RETRACT_START,
	output logic WORK_COUNT_OVER,
	output logic ABS_POSITION_WARNING,
	output logic [msf_pkg::NUM_PSW-1:0] POSITION_RANGE_SWITCH,
	output logic [msf_pkg::NUM_AXES-1:0] ZERO_INIT_COMPLETED
);
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] dat, input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++)
			if (strb[b])
				res[b*8 +: 8] = dat[b*8 +: 8];
		return res;
	endfunction

	function automatic logic [32:0] mag(input logic signed [31:0] a, input logic signed [31:0] b);
		logic signed [32:0] d;
		d = 33'(a) - 33'(b);
		return d[32] ? 33'(-d) : 33'(d);
	endfunction

	logic aw_rdy_q, aw_full_q, w_rdy_q, w_full_q, bvalid_q, ar_rdy_q, rvalid_q;
	logic [7:0] aw_addr_q;
	logic [31:0] w_data_q, rdata_q, rd_data;
	logic [3:0] w_strb_q;
	logic [1:0] bresp_q, rresp_q, ctrl_q;
	logic do_write, wr_err, rd_err;
	logic [31:0] inpos_range_q, work_count_q, work_max_q, abs_tol_q;
	logic [15:0] psw_axis_q;
	logic [31:0] lim_a_q [msf_pkg::NUM_PSW];
	logic [31:0] lim_b_q [msf_pkg::NUM_PSW];
	logic index_q, inpos_q, torque_q, retract_q, retract_start_q, over_q, warn_q;
	logic servo_d1_q, ready_d1_q, inpos_within, retract_set, warn_set;
	logic [msf_pkg::NUM_PSW-1:0] psw_q, psw_hit;
	logic [msf_pkg::NUM_AXES-1:0] zero_q, valid_q;
	logic [31:0] status;
	logic [7:0] wrel, rrel;

	// write channel acceptance
	assign do_write = aw_full_q && w_full_q && !bvalid_q;
	assign wrel = aw_addr_q - msf_pkg::OFS_PSW_BASE;
	assign rrel = S_AXI_ARADDR - msf_pkg::OFS_PSW_BASE;
	always_ff @(posedge CLK)
		if (RESET)
		begin
			aw_rdy_q <= 1'b0;
			aw_full_q <= 1'b0;
			aw_addr_q <= 8'h00;
			w_rdy_q <= 1'b0;
			w_full_q <= 1'b0;
			w_data_q <= 32'h0000_0000;
			w_strb_q <= 4'h0;
			bvalid_q <= 1'b0;
			bresp_q <= msf_pkg::RESP_OKAY;
		end
		else
		begin
			if (S_AXI_AWVALID && aw_rdy_q)
			begin
				aw_full_q <= 1'b1;
				aw_addr_q <= S_AXI_AWADDR;
				aw_rdy_q <= 1'b0;
			end
			else if (do_write)
				aw_full_q <= 1'b0;
			else if (!aw_full_q && !bvalid_q)
				aw_rdy_q <= 1'b1;
			if (S_AXI_WVALID && w_rdy_q)
			begin
				w_full_q <= 1'b1;
				w_data_q <= S_AXI_WDATA;
				w_strb_q <= S_AXI_WSTRB;
				w_rdy_q <= 1'b0;
			end
			else if (do_write)
				w_full_q <= 1'b0;
			else if (!w_full_q && !bvalid_q)
				w_rdy_q <= 1'b1;
			if (do_write)
			begin
				bvalid_q <= 1'b1;
				bresp_q <= wr_err ? msf_pkg::RESP_SLVERR : msf_pkg::RESP_OKAY;
			end
			else if (S_AXI_BREADY)
				bvalid_q <= 1'b0;
		end

	always_comb
	begin
		wr_err = 1'b0;
		if (aw_addr_q >= msf_pkg::OFS_PSW_BASE && aw_addr_q < msf_pkg::OFS_PSW_END)
			wr_err = 1'b0;
		else if (!(aw_addr_q inside {msf_pkg::OFS_CTRL, msf_pkg::OFS_INPOS_RANGE, msf_pkg::OFS_WORK_COUNT,
			msf_pkg::OFS_WORK_MAX, msf_pkg::OFS_ABS_TOL, msf_pkg::OFS_STATUS, msf_pkg::OFS_PSW_AXIS}))
			wr_err = 1'b1;
	end

	// configuration registers
	always_ff @(posedge CLK)
		if (RESET)
		begin
			ctrl_q <= msf_pkg::CTRL_RST;
			inpos_range_q <= msf_pkg::INPOS_RANGE_RST;
			work_max_q <= msf_pkg::WORK_MAX_RST;
			abs_tol_q <= msf_pkg::ABS_TOL_RST;
			psw_axis_q <= msf_pkg::PSW_AXIS_RST;
			for (int i = 0; i < msf_pkg::NUM_PSW; i++)
			begin
				lim_a_q[i] <= msf_pkg::LIMIT_RST;
				lim_b_q[i] <= msf_pkg::LIMIT_RST;
			end
		end
		else if (do_write)
		begin
			case (aw_addr_q)
				msf_pkg::OFS_CTRL: ctrl_q <= 2'(merge(32'(ctrl_q), w_data_q, w_strb_q));
				msf_pkg::OFS_INPOS_RANGE: inpos_range_q <= merge(inpos_range_q, w_data_q, w_strb_q);
				msf_pkg::OFS_WORK_MAX: work_max_q <= merge(work_max_q, w_data_q, w_strb_q);
				msf_pkg::OFS_ABS_TOL: abs_tol_q <= merge(abs_tol_q, w_data_q, w_strb_q);
				msf_pkg::OFS_PSW_AXIS: psw_axis_q <= 16'(merge(32'(psw_axis_q), w_data_q, w_strb_q));
				default:
					for (int i = 0; i < msf_pkg::NUM_PSW; i++)
						if (!wr_err && aw_addr_q >= msf_pkg::OFS_PSW_BASE && 32'(wrel[5:3]) == i)
						begin
							if (wrel[2])
								lim_b_q[i] <= merge(lim_b_q[i], w_data_q, w_strb_q);
							else
								lim_a_q[i] <= merge(lim_a_q[i], w_data_q, w_strb_q);
						end
			endcase
		end

	// read channel
	assign status = {4'h0, valid_q, psw_q, 4'h0, zero_q, 2'h0, warn_q, over_q, retract_q, torque_q, inpos_q, index_q};
	always_comb
	begin
		rd_data = 32'h0000_0000;
		rd_err = 1'b0;
		case (S_AXI_ARADDR)
			msf_pkg::OFS_CTRL: rd_data = 32'(ctrl_q);
			msf_pkg::OFS_INPOS_RANGE: rd_data = inpos_range_q;
			msf_pkg::OFS_WORK_COUNT: rd_data = work_count_q;
			msf_pkg::OFS_WORK_MAX: rd_data = work_max_q;
			msf_pkg::OFS_ABS_TOL: rd_data = abs_tol_q;
			msf_pkg::OFS_STATUS: rd_data = status;
			msf_pkg::OFS_PSW_AXIS: rd_data = 32'(psw_axis_q);
			default:
				if (S_AXI_ARADDR >= msf_pkg::OFS_PSW_BASE && S_AXI_ARADDR < msf_pkg::OFS_PSW_END)
					rd_data = rrel[2] ? lim_b_q[rrel[5:3]] : lim_a_q[rrel[5:3]];
				else
					rd_err = 1'b1;
		endcase
	end

	always_ff @(posedge CLK)
		if (RESET)
		begin
			ar_rdy_q <= 1'b0;
			rvalid_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
			rresp_q <= msf_pkg::RESP_OKAY;
		end
		else if (S_AXI_ARVALID && ar_rdy_q)
		begin
			ar_rdy_q <= 1'b0;
			rvalid_q <= 1'b1;
			rdata_q <= rd_data;
			rresp_q <= rd_err ? msf_pkg::RESP_SLVERR : msf_pkg::RESP_OKAY;
		end
		else if (rvalid_q)
		begin
			if (S_AXI_RREADY)
				rvalid_q <= 1'b0;
		end
		else
			ar_rdy_q <= 1'b1;

	// spindle flags
	assign inpos_within = mag(SPINDLE_DROOP, 32'sh0000_0000) <= 33'(inpos_range_q);
	always_ff @(posedge CLK)
		if (RESET)
		begin
			servo_d1_q <= 1'b0;
			ready_d1_q <= 1'b0;
			index_q <= 1'b0;
			inpos_q <= 1'b0;
			torque_q <= 1'b0;
		end
		else
		begin
			servo_d1_q <= SPINDLE_SERVO_ON_STATUS;
			ready_d1_q <= SPINDLE_READY_STATUS;
			if (!ctrl_q[msf_pkg::CTRL_SERIAL_LINK])
				index_q <= 1'b0;
			else if (SPINDLE_INDEX_PULSE)
				index_q <= 1'b1;
			else if ((servo_d1_q && !SPINDLE_SERVO_ON_STATUS) || (ready_d1_q && !SPINDLE_READY_STATUS))
				index_q <= 1'b0;
			if (!SYNC_TAP_CMD)
				inpos_q <= 1'b1;
			else if (SPINDLE_SERVO_ON_STATUS)
				inpos_q <= inpos_within;
			torque_q <= TORQUE_LIMIT_REQ_FIRST || TORQUE_LIMIT_REQ_SECOND;
		end

	// tapping, work count, absolute warning
	assign retract_set = TAP_CYCLE_ACTIVE && IN_CUT_FEED_REGION && (EMERGENCY_STOP || RESET_STOP ||
		(POWER_LOSS && ctrl_q[msf_pkg::CTRL_ABS_DETECT]));
	assign warn_set = POWER_ON_PULSE && ctrl_q[msf_pkg::CTRL_ABS_DETECT] &&
		mag(POS_AT_POWER_ON, POS_AT_POWER_OFF) > 33'(abs_tol_q);
	always_ff @(posedge CLK)
		if (RESET)
		begin
			retract_q <= 1'b0;
			retract_start_q <= 1'b0;
			work_count_q <= msf_pkg::WORK_COUNT_RST;
			over_q <= 1'b0;
			warn_q <= 1'b0;
		end
		else
		begin
			if (retract_set)
				retract_q <= 1'b1;
			else if (TAP_RETRACT_DONE || TAP_AXIS_MANUAL_MOVE)
				retract_q <= 1'b0;
			retract_start_q <= TAP_RETRACT_REQUEST && retract_q;
			if (do_write && aw_addr_q == msf_pkg::OFS_WORK_COUNT)
				work_count_q <= merge(work_count_q, w_data_q, w_strb_q);
			else if (WORK_COUNT_INC && work_count_q != msf_pkg::COUNT_SAT)
				work_count_q <= work_count_q + 32'h0000_0001;
			over_q <= work_max_q != 32'h0000_0000 && work_count_q >= work_max_q;
			if (warn_set)
				warn_q <= 1'b1;
			else if (do_write && aw_addr_q == msf_pkg::OFS_STATUS && w_strb_q[0] && w_data_q[msf_pkg::ST_ABS_WARNING])
				warn_q <= 1'b0;
		end

	// zero-point initialization and switch validity per axis
	always_ff @(posedge CLK)
		if (RESET)
		begin
			zero_q <= '0;
			valid_q <= '0;
		end
		else
		begin
			for (int k = 0; k < msf_pkg::NUM_AXES; k++)
			begin
				if (ZERO_INIT_ESTABLISHED[k] && ctrl_q[msf_pkg::CTRL_ABS_DETECT])
					zero_q[k] <= 1'b1;
				else if (ZERO_INIT_START[k] || POWER_ON_PULSE)
					zero_q[k] <= 1'b0;
				if (POWER_ON_PULSE)
					valid_q[k] <= ctrl_q[msf_pkg::CTRL_ABS_DETECT] && zero_q[k];
				else if (!ctrl_q[msf_pkg::CTRL_ABS_DETECT] && REF_RETURN_DONE[k])
					valid_q[k] <= 1'b1;
			end
		end

	// position range switches
	for (genvar gi = 0; gi < msf_pkg::NUM_PSW; gi++)
	begin : g_psw
		logic [1:0] sel;
		logic signed [31:0] pos, a, b, lo, hi;
		assign sel = psw_axis_q[gi*msf_pkg::AXIS_SEL_W +: msf_pkg::AXIS_SEL_W];
		assign pos = AXIS_POS[sel*32 +: 32];
		assign a = lim_a_q[gi];
		assign b = lim_b_q[gi];
		assign lo = (a < b) ? a : b;
		assign hi = (a < b) ? b : a;
		assign psw_hit[gi] = valid_q[sel] && pos >= lo && pos <= hi;
		always_ff @(posedge CLK)
			if (RESET)
				psw_q[gi] <= 1'b0;
			else
				psw_q[gi] <= psw_hit[gi];
	end

	// outputs straight from flops
	assign S_AXI_AWREADY = aw_rdy_q;
	assign S_AXI_WREADY = w_rdy_q;
	assign S_AXI_BVALID = bvalid_q;
	assign S_AXI_BRESP = bresp_q;
	assign S_AXI_ARREADY = ar_rdy_q;
	assign S_AXI_RVALID = rvalid_q;
	assign S_AXI_RDATA = rdata_q;
	assign S_AXI_RRESP = rresp_q;
	assign SPINDLE_INDEX_PASSED = index_q;
	assign POS_LOOP_IN_POSITION = inpos_q;
	assign SPINDLE_TORQUE_LIMIT_ACTIVE = torque_q;
	assign TAP_RETRACT_POSSIBLE = retract_q;
	assign TAP_RETRACT_START = retract_start_q;
	assign WORK_COUNT_OVER = over_q;
	assign ABS_POSITION_WARNING = warn_q;
	assign POSITION_RANGE_SWITCH = psw_q;
	assign ZERO_INIT_COMPLETED = zero_q;

	// checks
	logic [31:0] lag_cnt_q;
	logic chk_rst_q;
	// keeps checks quiet on the first edge after release, where flops still hold reset values
	always_ff @(posedge CLK)
		chk_rst_q <= RESET;
	always_ff @(posedge CLK)
		if (RESET)
			lag_cnt_q <= 32'h0000_0000;
		else if (psw_q[0] != psw_hit[0])
			lag_cnt_q <= lag_cnt_q + 32'h0000_0001;
		else
			lag_cnt_q <= 32'h0000_0000;

	default clocking cb @(posedge CLK); endclocking
	default disable iff (RESET || chk_rst_q);

	index_set_a: assert property (ctrl_q[0] && SPINDLE_INDEX_PULSE |=> SPINDLE_INDEX_PASSED)
		else $error("index flag did not set");
	index_drop_a: assert property (($fell(SPINDLE_READY_STATUS) || $fell(SPINDLE_SERVO_ON_STATUS)) &&
		!SPINDLE_INDEX_PULSE |=> !SPINDLE_INDEX_PASSED)
		else $error("index flag kept after status drop");
	index_link_a: assert property (!ctrl_q[0] |=> !SPINDLE_INDEX_PASSED)
		else $error("index flag without serial link");
	inpos_idle_a: assert property (!SYNC_TAP_CMD |=> POS_LOOP_IN_POSITION)
		else $error("in-position off outside sync tap");
	inpos_droop_a: assert property (SYNC_TAP_CMD && SPINDLE_SERVO_ON_STATUS |=>
		POS_LOOP_IN_POSITION == $past(inpos_within))
		else $error("in-position disagrees with droop");
	torque_follow_a: assert property (##1 SPINDLE_TORQUE_LIMIT_ACTIVE ==
		$past(TORQUE_LIMIT_REQ_FIRST || TORQUE_LIMIT_REQ_SECOND))
		else $error("torque flag wrong");
	retract_set_a: assert property (retract_set |=> TAP_RETRACT_POSSIBLE [*1])
		else $error("retract-possible not set");
	retract_gate_a: assert property (TAP_RETRACT_START |-> $past(TAP_RETRACT_POSSIBLE && TAP_RETRACT_REQUEST))
		else $error("retract started while not possible");
	count_zero_a: assert property (work_max_q == 32'h0000_0000 |=> !WORK_COUNT_OVER)
		else $error("count over with zero maximum");
	count_over_a: assert property (work_max_q != 32'h0000_0000 && work_count_q >= work_max_q |=> WORK_COUNT_OVER)
		else $error("count over missing");
	psw_lag_a: assert property (lag_cnt_q <= 32'(msf_pkg::PSW_PIPE_CYCLES) && lag_cnt_q < PSW_LAG_MAX_CYCLES)
		else $error("range switch lag too long");
	psw_incr_a: assert property (!ctrl_q[1] && POWER_ON_PULSE |=> ##1 POSITION_RANGE_SWITCH == 8'h00)
		else $error("range switch on before reference return");
	zero_clear_a: assert property (ZERO_INIT_START[0] && !ZERO_INIT_ESTABLISHED[0] |=> !ZERO_INIT_COMPLETED[0])
		else $error("zero init flag not cleared");

	retract_cycle_c: cover property (TAP_RETRACT_POSSIBLE ##[1:20] TAP_RETRACT_START);
	psw_enter_c: cover property ($rose(POSITION_RANGE_SWITCH[0]));
	count_over_c: cover property ($rose(WORK_COUNT_OVER));
	warn_c: cover property ($rose(ABS_POSITION_WARNING));
endmodule

// file: test/msf_seq_partner.sv
`timescale 1ns/1ps
// sequence program side: asks for tap retract while want_retract is set and the block allows it, or at any time while force_request is set
module msf_seq_partner (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// status seen and scenario commands
	input wire logic retract_possible,
	input wire logic want_retract,
	input wire logic force_request,
	// request to the block
	output logic retract_request
);
	always_ff @(posedge clk)
	begin
		if (reset)
			retract_request <= 1'b0;
		else
			retract_request <= force_request || (want_retract && retract_possible);
	end
endmodule

// file: test/machine_status_flag_generator_bench.sv
`timescale 1ns/1ps
module machine_status_flag_generator_bench;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic aw_v = 1'b0, w_v = 1'b0, ar_v = 1'b0;
	logic [7:0] aw_a = 8'h00, ar_a = 8'h00;
	logic [31:0] w_d = 32'h0;
	logic idx_p = 1'b0, servo = 1'b0, rdy = 1'b0, sync = 1'b0, tl1 = 1'b0, tl2 = 1'b0;
	logic tap = 1'b0, cut = 1'b0, done = 1'b0, manual = 1'b0, inc = 1'b0, pon = 1'b0;
	logic want = 1'b0, force_r = 1'b0, req;
	logic [2:0] stops = 3'h0;
	logic signed [31:0] droop = 32'h0, poff = 32'h0, pon_pos = 32'h0;
	logic [127:0] apos = 128'h0;
	logic [3:0] refr = 4'h0, zst = 4'h0, zest = 4'h0;
	logic awr, wrr, bv, arr, rv, idx, inp, tq, rp, rs, co, aw_w;
	logic [1:0] br, rr, rsp;
	logic [31:0] rdat, rdv;
	logic [7:0] psw;
	logic [3:0] zc;
	logic [31:0] dtab [0:2] = '{32'h0000_000A, 32'h0000_000B, 32'hFFFF_FFF6};
	int miscompares = 0;
	int checked = 0;
	int cycles = 0;

	msf_flags #(.PSW_LAG_MAX_CYCLES(16)) uut (.CLK(clk), .RESET(rst),
		.S_AXI_AWVALID(aw_v), .S_AXI_AWREADY(awr), .S_AXI_AWADDR(aw_a),
		.S_AXI_WVALID(w_v), .S_AXI_WREADY(wrr), .S_AXI_WDATA(w_d), .S_AXI_WSTRB(4'hF),
		.S_AXI_BVALID(bv), .S_AXI_BREADY(1'b1), .S_AXI_BRESP(br),
		.S_AXI_ARVALID(ar_v), .S_AXI_ARREADY(arr), .S_AXI_ARADDR(ar_a),
		.S_AXI_RVALID(rv), .S_AXI_RREADY(1'b1), .S_AXI_RDATA(rdat), .S_AXI_RRESP(rr),
		.SPINDLE_INDEX_PULSE(idx_p), .SPINDLE_SERVO_ON_STATUS(servo), .SPINDLE_READY_STATUS(rdy),
		.SYNC_TAP_CMD(sync), .SPINDLE_DROOP(droop),
		.TORQUE_LIMIT_REQ_FIRST(tl1), .TORQUE_LIMIT_REQ_SECOND(tl2),
		.TAP_CYCLE_ACTIVE(tap), .IN_CUT_FEED_REGION(cut), .EMERGENCY_STOP(stops[0]),
		.RESET_STOP(stops[1]), .POWER_LOSS(stops[2]), .TAP_RETRACT_REQUEST(req),
		.TAP_RETRACT_DONE(done), .TAP_AXIS_MANUAL_MOVE(manual), .WORK_COUNT_INC(inc),
		.POWER_ON_PULSE(pon), .POS_AT_POWER_OFF(poff), .POS_AT_POWER_ON(pon_pos),
		.AXIS_POS(apos), .REF_RETURN_DONE(refr), .ZERO_INIT_START(zst),
		.ZERO_INIT_ESTABLISHED(zest), .SPINDLE_INDEX_PASSED(idx), .POS_LOOP_IN_POSITION(inp),
		.SPINDLE_TORQUE_LIMIT_ACTIVE(tq), .TAP_RETRACT_POSSIBLE(rp), .TAP_RETRACT_START(rs),
		.WORK_COUNT_OVER(co), .ABS_POSITION_WARNING(aw_w), .POSITION_RANGE_SWITCH(psw),
		.ZERO_INIT_COMPLETED(zc));

	msf_seq_partner seq (.clk(clk), .reset(rst), .retract_possible(rp), .want_retract(want),
		.force_request(force_r), .retract_request(req));

	initial
	begin
		forever #5 clk = ~clk;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic ad;
		logic dd;
		ad = 1'b0;
		dd = 1'b0;
		aw_a <= a;
		w_d <= d;
		aw_v <= 1'b1;
		w_v <= 1'b1;
		while (!(ad && dd))
		begin
			@(posedge clk);
			ad = ad || (awr === 1'b1);
			dd = dd || (wrr === 1'b1);
			aw_v <= !ad;
			w_v <= !dd;
		end
		do @(posedge clk); while (bv !== 1'b1);
		chk(br, er);
	endtask

	task automatic rd(input logic [7:0] a);
		ar_a <= a;
		ar_v <= 1'b1;
		do @(posedge clk); while (arr !== 1'b1);
		ar_v <= 1'b0;
		do @(posedge clk); while (rv !== 1'b1);
		rdv = rdat;
		rsp = rr;
	endtask

	task automatic endt(input string s);
		$display("test %s finished", s);
	endtask

	task complete_run;
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	always @(posedge clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 5000)
		begin
			miscompares++;
			complete_run;
		end
	end

	initial
	begin
		tick(10);
		chk({idx, inp, tq, rp, rs, co, aw_w, psw, zc}, 32'h0);
		tick(2);
		rst <= 1'b0;
		tick(2);
		chk(inp, 1'b1);
		rd(msf_pkg::OFS_PSW_AXIS);
		chk(rdv, 32'h0);
		endt("reset");
		for (int i = 0; i < 4; i++)
		begin
			{tl2, tl1} <= i[1:0];
			tick(2);
			chk(tq, i != 0);
		end
		{tl2, tl1} <= 2'h0;
		endt("torque");
		wr(msf_pkg::OFS_PSW_BASE, 32'h0000_0064, msf_pkg::RESP_OKAY);
		wr(msf_pkg::OFS_PSW_BASE + 8'h04, 32'hFFFF_FF9C, msf_pkg::RESP_OKAY);
		wr(msf_pkg::OFS_PSW_BASE + 8'h08, 32'hFFFF_FFCE, msf_pkg::RESP_OKAY);
		wr(msf_pkg::OFS_PSW_BASE + 8'h0C, 32'h0000_0032, msf_pkg::RESP_OKAY);
		apos[31:0] <= 32'h0000_0014;
		tick(2);
		chk(psw, 8'h00);
		refr <= 4'h1;
		tick(1);
		refr <= 4'h0;
		tick(2);
		chk(psw, 8'h03);
		apos[31:0] <= 32'hFFFF_FFB5;
		tick(2);
		chk(psw, 8'h01);
		apos[31:0] <= 32'h0000_0096;
		tick(2);
		chk(psw, 8'h00);
		endt("range");
		servo <= 1'b1;
		rdy <= 1'b1;
		idx_p <= 1'b1;
		tick(1);
		idx_p <= 1'b0;
		tick(2);
		chk(idx, 1'b0);
		wr(msf_pkg::OFS_CTRL, 32'h0000_0003, msf_pkg::RESP_OKAY);
		for (int i = 0; i < 2; i++)
		begin
			idx_p <= 1'b1;
			tick(1);
			idx_p <= 1'b0;
			tick(2);
			chk(idx, 1'b1);
			if (i == 0)
				servo <= 1'b0;
			else
				rdy <= 1'b0;
			tick(2);
			chk(idx, 1'b0);
			servo <= 1'b1;
			rdy <= 1'b1;
			tick(1);
		end
		endt("index");
		wr(msf_pkg::OFS_INPOS_RANGE, 32'h0000_000A, msf_pkg::RESP_OKAY);
		sync <= 1'b1;
		for (int i = 0; i < 3; i++)
		begin
			droop <= dtab[i];
			tick(2);
			chk(inp, i != 1);
		end
		sync <= 1'b0;
		droop <= 32'h0000_0063;
		tick(2);
		chk(inp, 1'b1);
		endt("in position");
		force_r <= 1'b1;
		tick(3);
		chk(rs, 1'b0);
		force_r <= 1'b0;
		for (int c = 0; c < 3; c++)
		begin
			tap <= 1'b1;
			cut <= 1'b1;
			stops[c] <= 1'b1;
			tick(1);
			stops <= 3'h0;
			tick(2);
			chk(rp, 1'b1);
			want <= 1'b1;
			tick(3);
			chk(rs, 1'b1);
			if (c == 1)
				manual <= 1'b1;
			else
				done <= 1'b1;
			tick(1);
			manual <= 1'b0;
			done <= 1'b0;
			want <= 1'b0;
			tick(2);
			chk(rp, 1'b0);
		end
		tap <= 1'b0;
		cut <= 1'b0;
		endt("retract");
		wr(msf_pkg::OFS_WORK_COUNT, 32'h0000_0005, msf_pkg::RESP_OKAY);
		tick(2);
		chk(co, 1'b0);
		wr(msf_pkg::OFS_WORK_MAX, 32'h0000_0007, msf_pkg::RESP_OKAY);
		inc <= 1'b1;
		tick(2);
		inc <= 1'b0;
		tick(2);
		chk(co, 1'b1);
		rd(msf_pkg::OFS_WORK_COUNT);
		chk(rdv, 32'h0000_0007);
		wr(msf_pkg::OFS_WORK_MAX, 32'h0, msf_pkg::RESP_OKAY);
		tick(2);
		chk(co, 1'b0);
		endt("count");
		zest <= 4'h2;
		tick(1);
		zest <= 4'h0;
		tick(2);
		chk(zc, 4'h2);
		wr(msf_pkg::OFS_ABS_TOL, 32'h0000_0005, msf_pkg::RESP_OKAY);
		for (int i = 0; i < 2; i++)
		begin
			pon_pos <= (i == 0) ? 32'hFFFF_FFFA : 32'h0000_0005;
			pon <= 1'b1;
			tick(1);
			pon <= 1'b0;
			tick(2);
			chk(aw_w, i == 0);
			chk(zc, 4'h0);
			rd(msf_pkg::OFS_STATUS);
			chk(rdv[27:24], 4'h2);
			wr(msf_pkg::OFS_STATUS, 32'h0000_0020, msf_pkg::RESP_OKAY);
			zest <= 4'h2;
			tick(1);
			zest <= 4'h0;
		end
		zst <= 4'h2;
		tick(1);
		zst <= 4'h0;
		tick(2);
		chk(zc, 4'h0);
		endt("absolute");
		wr(msf_pkg::OFS_CTRL, 32'h0000_0001, msf_pkg::RESP_OKAY);
		apos[31:0] <= 32'h0000_0014;
		refr <= 4'h1;
		tick(1);
		refr <= 4'h0;
		tick(2);
		chk(psw, 8'h03);
		pon <= 1'b1;
		tick(1);
		pon <= 1'b0;
		tick(2);
		chk(psw, 8'h00);
		endt("incremental power-up");
		rd(8'h1C);
		chk(rsp, msf_pkg::RESP_SLVERR);
		chk(rdv, 32'h0);
		wr(8'h64, 32'hFFFF_FFFF, msf_pkg::RESP_SLVERR);
		rd(msf_pkg::OFS_PSW_BASE);
		chk(rdv, 32'h0000_0064);
		endt("unmapped");
		complete_run;
	end
endmodule
